// *** bench/pause_cfg_chk.sv ***
// Checker of bus timing, reset values and hold-off cause at the block ports
`timescale 1ns/1ps
module pause_cfg_chk (
   // Clock and reset
   input wire logic                      clk,
   input wire logic                      sys_rst,
   // Register bus
   input wire logic [11:0]               avs_address,
   input wire logic                      avs_read,
   input wire logic                      avs_write,
   input wire logic [31:0]               avs_writedata,
   input wire logic [3:0]                avs_byteenable,
   input wire logic [31:0]               avs_readdata,
   input wire logic                      avs_waitrequest,
   // Timer and frame side
   input wire logic [7:0]                xoff_sent,
   input wire logic [7:0]                holdoff_active,
   input wire logic [127:0]              pause_time,
   input wire pause_cfg_pkg::frame_addr_s frame_addr
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   logic [15:0] hi_q;  // Last half-word written to the destination high register
   logic        hi_w;  // Write with both low byte lanes enabled to the destination high register
   logic        rd_ok; // Read answered this cycle
   assign hi_w  = avs_write && avs_address == 12'h060e && avs_byteenable[1:0] == 2'b11;
   assign rd_ok = avs_read && !avs_waitrequest;
   // Capture the written half-word for the follow check
   always_ff @(posedge clk) begin
      if (hi_w) begin
         hi_q <= avs_writedata[15:0];
      end
   end
   a_write_no_wait: assert property (avs_write |-> !avs_waitrequest)
      else $error("write was stalled");
   a_read_first_wait: assert property ($rose(avs_read) |-> avs_waitrequest)
      else $error("read answered in its first cycle");
   a_read_answer: assert property (avs_read && avs_waitrequest |=> !avs_waitrequest)
      else $error("read not answered in its second cycle");
   a_reset_addr: assert property ($past(sys_rst) |-> frame_addr == 96'h0180_c200_0001_e100_cbfc_5add)
      else $error("frame addresses not at reset value");
   a_reset_pause: assert property ($past(sys_rst) |-> pause_time == {8{16'hffff}} && holdoff_active == 8'h00)
      else $error("pause times or hold-off not at reset value");
   a_dest_follow: assert property (hi_w |-> ##2 frame_addr.dest[47:32] == hi_q)
      else $error("destination high not carried to frame");
   a_holdoff_cause: assert property ((holdoff_active & ~$past(holdoff_active) & ~$past(xoff_sent)) == 8'h00)
      else $error("hold-off started without xoff");
   a_index_width: assert property (rd_ok && avs_address == 12'h060a |-> avs_readdata[31:3] == 29'h0)
      else $error("queue index wider than three bits");
   a_enable_width: assert property (rd_ok && avs_address == 12'h060b |-> avs_readdata[31:1] == 31'h0)
      else $error("hold-off enable wider than one bit");
endmodule // pause_cfg_chk
bind tx_priority_pause_config pause_cfg_chk pause_cfg_chk_inst (.clk(clk), .sys_rst(sys_rst),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .xoff_sent(xoff_sent),
   .holdoff_active(holdoff_active), .pause_time(pause_time), .frame_addr(frame_addr));

// *** bench/tx_priority_pause_config_bench.sv ***
// Self-checking bench of the priority pause configuration block
`timescale 1ns/1ps
module tx_priority_pause_config_bench;
   logic                      clk, sys_rst, avs_read, avs_write, avs_waitrequest;
   logic [11:0]               avs_address;
   logic [31:0]               avs_writedata, avs_readdata;
   logic [3:0]                avs_byteenable;
   logic [7:0]                xoff_sent, holdoff_active;
   logic [127:0]              pause_time;
   pause_cfg_pkg::frame_addr_s frame_addr;
   int                        num_errors = 0;
   int                        comparisons = 0;
   // Reset value table: address and expected read data
   logic [11:0] ra [10] = '{12'h060a, 12'h060b, 12'h060c, 12'h060d, 12'h060e,
                            12'h060f, 12'h0610, 12'h0609, 12'h0608, 12'h0611};
   logic [31:0] rv [10] = '{32'h0, 32'h0, 32'h0, 32'hc200_0001, 32'h0180,
                            32'hcbfc_5add, 32'he100, 32'hffff, 32'h0, 32'hff};
   tx_priority_pause_config tx_priority_pause_config_inst (.clk(clk), .sys_rst(sys_rst),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .xoff_sent(xoff_sent),
      .holdoff_active(holdoff_active), .pause_time(pause_time), .frame_addr(frame_addr));
   xoff_partner xoff_partner_inst (.clk(clk), .xoff_sent(xoff_sent));
   // Clock of 40 ns period
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // Compare and count
   task automatic chk(input string n, input logic [63:0] got, input logic [63:0] exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", n, exp, got);
      end
   endtask
   // One bus cycle, held until waitrequest is seen low
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] be, output logic [31:0] q);
      @(posedge clk);
      avs_address    <= a;
      avs_writedata  <= d;
      avs_byteenable <= be;
      avs_write      <= w;
      avs_read       <= !w;
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] be);
      logic [31:0] q;
      bus(1'b1, a, d, be, q);
   endtask
   task automatic rdchk(input logic [11:0] a, input logic [31:0] e, input string n);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, 4'hf, q);
      chk(n, q, e);
   endtask
   // XOFF on queue q, then count hold-off cycles
   task automatic ho(input int q, input int e);
      int n;
      n = 0;
      xoff_partner_inst.send(q);
      repeat (40) begin
         @(posedge clk);
         n += holdoff_active[q];
      end
      chk("holdoff cycles", n, e);
   endtask
   // Synchronous reset for 5 cycles
   task automatic do_reset();
      sys_rst <= 1'b1;
      repeat (5) @(posedge clk);
      sys_rst <= 1'b0;
   endtask
   // Verdict and end of run
   task automatic stop_test();
      $display("comparisons %0d num_errors %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // Watchdog against a hung handshake
   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      stop_test();
   end
   // Main sequence
   initial begin
      sys_rst = 1'b1;
      {avs_read, avs_write, avs_address, avs_writedata, avs_byteenable} = '0;
      do_reset();
      for (int i = 0; i < 10; i++) rdchk(ra[i], rv[i], "reset value");
      chk("dest", frame_addr.dest, 48'h0180_c200_0001);
      chk("src", frame_addr.src, 48'he100_cbfc_5add);
      rdchk(12'h0700, 32'h0, "unmapped");
      rdchk(12'h0613, 32'h0, "hold-off idle");
      // Fill the pause table, then read it back in reverse
      for (int q = 0; q < 8; q++) begin
         wr(12'h060a, q, 4'hf);
         wr(12'h0609, 32'h1000 + q, 4'hf);
      end
      for (int q = 7; q >= 0; q--) begin
         wr(12'h060a, q, 4'hf);
         rdchk(12'h060a, q, "index");
         rdchk(12'h0609, 32'h1000 + q, "pause entry");
         chk("pause out", pause_time[16*q +: 16], 16'h1000 + q);
      end
      // Partial write is ignored, broadcast and unicast pass unchanged
      wr(12'h060e, 32'h0000_1234, 4'b1100);
      rdchk(12'h060e, 32'h0180, "dest high kept");
      wr(12'h060d, 32'hffff_ffff, 4'hf);
      wr(12'h060e, 32'h0000_ffff, 4'hf);
      rdchk(12'h060e, 32'hffff, "dest high");
      chk("dest", frame_addr.dest, 48'hffff_ffff_ffff);
      wr(12'h060d, 32'h0a0b_0c0d, 4'hf);
      wr(12'h060e, 32'h0000_0201, 4'hf);
      wr(12'h060f, 32'h1122_3344, 4'hf);
      wr(12'h0610, 32'h0000_5566, 4'hf);
      rdchk(12'h060f, 32'h1122_3344, "src low");
      chk("dest", frame_addr.dest, 48'h0201_0a0b_0c0d);
      chk("src", frame_addr.src, 48'h5566_1122_3344);
      // Hold-off of queue 2 against the global value
      wr(12'h060a, 2, 4'hf);
      wr(12'h0608, 5, 4'hf);
      ho(2, 5);
      wr(12'h060c, 9, 4'hf);
      ho(2, 5);
      wr(12'h060b, 1, 4'hf);
      ho(2, 9);
      wr(12'h0608, 12, 4'hf);
      ho(2, 12);
      wr(12'h0611, 32'h0000_00fb, 4'hf);
      ho(2, 9);
      // Second reset in mid-run
      do_reset();
      rdchk(12'h060a, 32'h0, "index reset");
      rdchk(12'h060b, 32'h0, "enable reset");
      rdchk(12'h0609, 32'hffff, "pause reset");
      stop_test();
   end
endmodule // tx_priority_pause_config_bench

// *** bench/xoff_partner.sv ***
// Model of the pause frame sender that reports an XOFF per queue
`timescale 1ns/1ps
module xoff_partner (
   // Clock
   input wire logic  clk,
   // XOFF report per queue
   output logic [7:0] xoff_sent
);
   initial xoff_sent = 8'h00;
   // One-cycle XOFF report on queue q, launched right after an edge
   task automatic send(input int q);
      @(posedge clk);
      xoff_sent <= 8'h01 << q;
      @(posedge clk);
      xoff_sent <= 8'h00;
   endtask
endmodule // xoff_partner

// *** src/pause_cfg_pkg.sv ***
// Package of register map, field layout, reset values and timing for priority pause configuration
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
package pause_cfg_pkg;

   // Register indices as printed; byte address is four times the index
   localparam logic [11:0] IDX_QUEUE_HOLDOFF  = 12'h0608;
   localparam logic [11:0] IDX_PAUSE_QUANTA   = 12'h0609;
   localparam logic [11:0] IDX_QUEUE_INDEX    = 12'h060a;
   localparam logic [11:0] IDX_GLOBAL_HO_EN   = 12'h060b;
   localparam logic [11:0] IDX_GLOBAL_HO_QUA  = 12'h060c;
   localparam logic [11:0] IDX_DEST_LOW       = 12'h060d;
   localparam logic [11:0] IDX_DEST_HIGH      = 12'h060e;
   localparam logic [11:0] IDX_SRC_LOW        = 12'h060f;
   localparam logic [11:0] IDX_SRC_HIGH       = 12'h0610;
   // Control and status registers of this block
   localparam logic [11:0] IDX_QUEUE_HO_EN    = 12'h0611;
   localparam logic [11:0] IDX_HOLDOFF_LOAD   = 12'h0612;
   localparam logic [11:0] IDX_HOLDOFF_BUSY   = 12'h0613;

   // Word address width on the bus (byte address bits [13:2])
   localparam int ADDR_W = 12;

   // Queue count and index width
   localparam int QUEUES  = 8;
   localparam int QIDX_W  = 3;
   localparam int QUANT_W = 16;

   // Bit times in one quantum; one quantum is one clock cycle here
   localparam int BIT_TIMES_PER_QUANTUM = 512;
   localparam int CYCLES_PER_QUANTUM    = 1;

   // Reset values
   localparam logic [2:0]  RST_QUEUE_INDEX = 3'h0;
   localparam logic        RST_GLOBAL_EN   = 1'b0;
   localparam logic [15:0] RST_GLOBAL_QUA  = 16'h0000;
   localparam logic [15:0] RST_PAUSE_QUA   = 16'hffff;
   localparam logic [15:0] RST_QUEUE_HO    = 16'h0000;
   localparam logic [31:0] RST_DEST_LOW    = 32'hc200_0001;
   localparam logic [15:0] RST_DEST_HIGH   = 16'h0180;
   localparam logic [31:0] RST_SRC_LOW     = 32'hcbfc_5add;
   localparam logic [15:0] RST_SRC_HIGH    = 16'he100;
   localparam logic [7:0]  RST_QUEUE_HO_EN = 8'hff;

   // Read data for an unmapped word
   localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

   // Pause frame addresses handed to the frame builder
   typedef struct packed {
      logic [47:0] dest;
      logic [47:0] src;
   } frame_addr_s;

endpackage : pause_cfg_pkg

// *** src/queue_table_mem.sv ***
// Small per-queue table memory with registered read data
`timescale 1ns/1ps
module queue_table_mem (
   // Clock and reset
   input  wire logic                          clk,
   input  wire logic                          sys_rst,
   // Write port
   input  wire logic                          wr_en,
   input  wire logic [pause_cfg_pkg::QIDX_W-1:0] wr_idx,
   input  wire logic [15:0]                   wr_data,
   // Registered read port
   input  wire logic [pause_cfg_pkg::QIDX_W-1:0] rd_idx,
   output logic [15:0]                        rd_data,
   // All entries, for the timer logic and the pause time output
   output logic [pause_cfg_pkg::QUEUES*16-1:0] all_entries,
   // Reset value of every entry
   input  wire logic [15:0]                   reset_value
);

   logic [15:0] entry_q [pause_cfg_pkg::QUEUES];   // Table storage

   // One entry per queue; only the selected entry is written
   for (genvar g = 0; g < pause_cfg_pkg::QUEUES; g++) begin : g_entry
      always_ff @(posedge clk) begin
         if (sys_rst) begin
            entry_q[g] <= 16'h0000;
         end else if (wr_en && wr_idx == pause_cfg_pkg::QIDX_W'(g)) begin
            entry_q[g] <= wr_data;
         end
      end
      assign all_entries[g*16 +: 16] = entry_q[g] ^ reset_value;
   end

   // Registered read of the selected entry
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rd_data <= 16'h0000;
      end else begin
         rd_data <= entry_q[rd_idx] ^ reset_value;
      end
   end

endmodule // queue_table_mem

// *** src/tx_priority_pause_config.sv ***
// Priority pause configuration registers and per-queue hold-off timers
`timescale 1ns/1ps
module tx_priority_pause_config (
   // Clock and reset
   input  wire logic                 clk,
   input  wire logic                 sys_rst,
   // Avalon-MM slave, word addressed
   input  wire logic [11:0]          avs_address,
   input  wire logic                 avs_read,
   input  wire logic                 avs_write,
   input  wire logic [31:0]          avs_writedata,
   input  wire logic [3:0]           avs_byteenable,
   output logic [31:0]               avs_readdata,
   output logic                      avs_waitrequest,
   // XOFF sent on a queue, starts its hold-off timer
   input  wire logic [7:0]           xoff_sent,
   // Hold-off active per queue
   output logic [7:0]                holdoff_active,
   // Pause time of each queue for XOFF frames
   output logic [127:0]              pause_time,
   // Pause frame addresses
   output pause_cfg_pkg::frame_addr_s frame_addr
);

   //---------------------------------------------------------------------------
   // Register state
   //---------------------------------------------------------------------------
   logic [2:0]  qidx_q;        // Selected queue
   logic        gen_q;         // Global hold-off enable
   logic [15:0] gqua_q;        // Global hold-off quanta
   logic [31:0] dlo_q;         // Destination low word
   logic [15:0] dhi_q;         // Destination high half
   logic [31:0] slo_q;         // Source low word
   logic [15:0] shi_q;         // Source high half
   logic [7:0]  qho_en_q;      // Per-queue hold-off enable
   logic [15:0] timer_q [8];   // Hold-off down-counters
   logic        phase_q;       // Read access phase
   logic [31:0] rdata_q;       // Read data
   logic [7:0]  active_q;      // Hold-off active
   logic [127:0] ptime_q;      // Pause time copy
   pause_cfg_pkg::frame_addr_s faddr_q;

   //---------------------------------------------------------------------------
   // Decode
   //---------------------------------------------------------------------------
   wire logic wr_full  = avs_write && (avs_byteenable == 4'hf);
   wire logic wr_lo    = avs_write && (avs_byteenable[1:0] == 2'h3);
   wire logic hit_ho   = avs_address == pause_cfg_pkg::IDX_QUEUE_HOLDOFF;
   wire logic hit_pq   = avs_address == pause_cfg_pkg::IDX_PAUSE_QUANTA;
   wire logic hit_qi   = avs_address == pause_cfg_pkg::IDX_QUEUE_INDEX;
   wire logic hit_gen  = avs_address == pause_cfg_pkg::IDX_GLOBAL_HO_EN;
   wire logic hit_gq   = avs_address == pause_cfg_pkg::IDX_GLOBAL_HO_QUA;
   wire logic hit_dl   = avs_address == pause_cfg_pkg::IDX_DEST_LOW;
   wire logic hit_dh   = avs_address == pause_cfg_pkg::IDX_DEST_HIGH;
   wire logic hit_sl   = avs_address == pause_cfg_pkg::IDX_SRC_LOW;
   wire logic hit_sh   = avs_address == pause_cfg_pkg::IDX_SRC_HIGH;
   wire logic hit_qe   = avs_address == pause_cfg_pkg::IDX_QUEUE_HO_EN;
   wire logic hit_bz   = avs_address == pause_cfg_pkg::IDX_HOLDOFF_BUSY;

   // Table write strobes for the selected queue
   wire logic ho_we = wr_lo && hit_ho;
   wire logic pq_we = wr_lo && hit_pq;

   //---------------------------------------------------------------------------
   // Per-queue tables
   //---------------------------------------------------------------------------
   logic [15:0]  ho_rd;    // Selected queue hold-off
   logic [15:0]  pq_rd;    // Selected queue pause time
   logic [127:0] ho_all;   // All hold-off entries
   logic [127:0] pq_all;   // All pause times

   // Hold-off table, entries reset to zero
   queue_table_mem u_holdoff_tbl (
      .clk         (clk),
      .sys_rst     (sys_rst),
      .wr_en       (ho_we),
      .wr_idx      (qidx_q),
      .wr_data     (avs_writedata[15:0] ^ pause_cfg_pkg::RST_QUEUE_HO),
      .rd_idx      (qidx_q),
      .rd_data     (ho_rd),
      .all_entries (ho_all),
      .reset_value (pause_cfg_pkg::RST_QUEUE_HO)
   );

   // Pause time table, entries reset to all ones by stored inversion
   queue_table_mem u_pause_tbl (
      .clk         (clk),
      .sys_rst     (sys_rst),
      .wr_en       (pq_we),
      .wr_idx      (qidx_q),
      .wr_data     (avs_writedata[15:0] ^ pause_cfg_pkg::RST_PAUSE_QUA),
      .rd_idx      (qidx_q),
      .rd_data     (pq_rd),
      .all_entries (pq_all),
      .reset_value (pause_cfg_pkg::RST_PAUSE_QUA)
   );

   //---------------------------------------------------------------------------
   // Bus answer: writes in one cycle, reads in two (table read is registered)
   //---------------------------------------------------------------------------
   wire logic [31:0] rd_mux =
      hit_ho  ? {16'h0000, ho_rd} :
      hit_pq  ? {16'h0000, pq_rd} :
      hit_qi  ? {29'h0, qidx_q} :
      hit_gen ? {31'h0, gen_q} :
      hit_gq  ? {16'h0000, gqua_q} :
      hit_dl  ? dlo_q :
      hit_dh  ? {16'h0000, dhi_q} :
      hit_sl  ? slo_q :
      hit_sh  ? {16'h0000, shi_q} :
      hit_qe  ? {24'h0, qho_en_q} :
      hit_bz  ? {24'h0, active_q} : pause_cfg_pkg::UNMAPPED_DATA;

   // Read phase: first cycle stalls, second answers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         phase_q <= 1'b0;
      end else begin
         phase_q <= avs_read && !phase_q;
      end
   end

   // Wait while a read is in its first cycle
   always_comb begin
      avs_waitrequest = avs_read && !phase_q;
   end

   // Read data register
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rdata_q <= 32'h0000_0000;
      end else if (avs_read && phase_q) begin
         rdata_q <= rd_mux;
      end
   end
   assign avs_readdata = (avs_read && phase_q) ? rd_mux : rdata_q;

   //---------------------------------------------------------------------------
   // Configuration registers
   //---------------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         qidx_q   <= pause_cfg_pkg::RST_QUEUE_INDEX;
         gen_q    <= pause_cfg_pkg::RST_GLOBAL_EN;
         gqua_q   <= pause_cfg_pkg::RST_GLOBAL_QUA;
         dlo_q    <= pause_cfg_pkg::RST_DEST_LOW;
         dhi_q    <= pause_cfg_pkg::RST_DEST_HIGH;
         slo_q    <= pause_cfg_pkg::RST_SRC_LOW;
         shi_q    <= pause_cfg_pkg::RST_SRC_HIGH;
         qho_en_q <= pause_cfg_pkg::RST_QUEUE_HO_EN;
      end else begin
         if (wr_lo && hit_qi) qidx_q <= avs_writedata[2:0];
         if (wr_lo && hit_gen) gen_q <= avs_writedata[0];
         if (wr_lo && hit_gq) gqua_q <= avs_writedata[15:0];
         if (wr_full && hit_dl) dlo_q <= avs_writedata;
         if (wr_lo && hit_dh) dhi_q <= avs_writedata[15:0];
         if (wr_full && hit_sl) slo_q <= avs_writedata;
         if (wr_lo && hit_sh) shi_q <= avs_writedata[15:0];
         if (wr_lo && hit_qe) qho_en_q <= avs_writedata[7:0];
      end
   end

   //---------------------------------------------------------------------------
   // Hold-off timers, one per queue, one quantum per clock
   //---------------------------------------------------------------------------
   for (genvar q = 0; q < 8; q++) begin : g_timer
      wire logic [15:0] own_ho = qho_en_q[q] ? ho_all[q*16 +: 16] : 16'h0000;
      // Longer of own and global delay when global is enabled
      wire logic [15:0] eff_ho = (gen_q && gqua_q > own_ho) ? gqua_q : own_ho;

      always_ff @(posedge clk) begin
         if (sys_rst) begin
            timer_q[q] <= 16'h0000;
         end else if (xoff_sent[q]) begin
            timer_q[q] <= eff_ho;
         end else if (timer_q[q] != 16'h0000) begin
            timer_q[q] <= timer_q[q] - 16'h0001;
         end
      end

      always_ff @(posedge clk) begin
         if (sys_rst) begin
            active_q[q] <= 1'b0;
         end else begin
            active_q[q] <= xoff_sent[q] ? (eff_ho != 16'h0000) : (timer_q[q] > 16'h0001);
         end
      end
   end

   //---------------------------------------------------------------------------
   // Outputs to the frame builder
   //---------------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ptime_q <= {8{pause_cfg_pkg::RST_PAUSE_QUA}};
         faddr_q <= '{dest: {pause_cfg_pkg::RST_DEST_HIGH, pause_cfg_pkg::RST_DEST_LOW},
                      src:  {pause_cfg_pkg::RST_SRC_HIGH, pause_cfg_pkg::RST_SRC_LOW}};
      end else begin
         ptime_q      <= pq_all;
         faddr_q.dest <= {dhi_q, dlo_q};
         faddr_q.src  <= {shi_q, slo_q};
      end
   end

   assign holdoff_active = active_q;
   assign pause_time     = ptime_q;
   assign frame_addr     = faddr_q;

endmodule // tx_priority_pause_config
